// *** rtl/cmou_params.svh ***
// Offsets, field positions, reset values and timing counts of the compare output unit
`ifndef CMOU_PARAMS_SVH
`define CMOU_PARAMS_SVH
`define CMOU_ADDR_W 4
`define CMOU_OFS_CTRL 4'h0
`define CMOU_OFS_COUNT 4'h1
`define CMOU_OFS_CMP 4'h2
`define CMOU_OFS_STROBE 4'h3
`define CMOU_OFS_STAT 4'h4
`define CMOU_OFS_MASK 4'h5
`define CMOU_OFS_PIN 4'h6
`define CMOU_CTRL_WGM_LSB 0
`define CMOU_CTRL_ACT_LSB 4
`define CMOU_CTRL_DIR_BIT 6
`define CMOU_CTRL_PORT_BIT 7
`define CMOU_CTRL_RUN_BIT 8
`define CMOU_CTRL_DIV_LSB 16
`define CMOU_STAT_MATCH_BIT 0
`define CMOU_STAT_OVF_BIT 1
`define CMOU_COUNT_MAX 16'hFFFF
`define CMOU_COUNT_BOTTOM 16'h0000
`define CMOU_TOP_8 16'h00FF
`define CMOU_TOP_9 16'h01FF
`define CMOU_TOP_10 16'h03FF
`define CMOU_DIV_RESET 16'h0000
`endif

// *** rtl/cmou_pkg.sv ***
// Types shared by the compare output unit
package cmou_pkg;
	typedef enum logic [1:0] {CMOU_ACT_NONE, CMOU_ACT_TOGGLE, CMOU_ACT_CLEAR, CMOU_ACT_SET} cmou_act_e;
	typedef struct packed {
		logic [3:0] waveform_mode_select;
		logic [1:0] output_action_select;
		logic output_pin_direction_bit;
		logic port_value;
		logic run;
		logic [15:0] divider;
	} cmou_ctrl_s;
	typedef struct packed {
		logic out;
		logic oe;
	} cmou_pin_s;
endpackage : cmou_pkg

// *** rtl/cmou_tick_div.sv ***
// Timer clock enable divider
`timescale 1ns/100ps
module cmou_tick_div
	import cmou_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic [15:0] divider,
	// Tick
	output logic tick
);
	logic [15:0] cnt_q;
	wire wrap = (cnt_q >= divider);
	always_ff @(posedge clk or posedge rst)
		if (rst)
			cnt_q <= 16'h0000;
		else if (!run || wrap)
			cnt_q <= 16'h0000;
		else
			cnt_q <= cnt_q + 16'h0001;
	assign tick = run & wrap;
endmodule : cmou_tick_div

// *** rtl/cmou_top.sv ***
// Compare match output unit of one 16-bit timer channel with Avalon-MM registers
//
// Contract
// - Force strobe acts like match, no flag; the code ignores the strobe in PWM modes
// - Counter write blocks next tick's match
// - Write equal to compare loses match
// - Action select unbuffered, applies next match
// - Reset clears output state
// - Nonzero action select overrides port value
// - Direction bit still controls pin enable
// - Action zero leaves output unchanged
// - Action select ignores input capture
// - Counting depends only on mode field
// - PWM modes choose inverted or not
// - Non-PWM: set, clear or toggle
// - 16-bit comparator, flag next tick
// - Flag cleared by ack or one-write
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "cmou_params.svh"
module cmou_top
	import cmou_pkg::*;
#(
	parameter int CW = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [`CMOU_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt
	input wire logic irq_ack,
	output logic irq,
	// Output pin
	output cmou_pkg::cmou_pin_s pin
);
	cmou_ctrl_s ctrl_q;
	logic [CW-1:0] count_q, count_d;
	logic [CW-1:0] cmp_q;
	logic [1:0] stat_q, mask_q;
	logic oc_q, oc_d;
	logic down_q, down_d;
	logic block_q;
	logic match_pend_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic tick;

	// Single-wait-state answer keeps read data registered
	wire access = avs_read | avs_write;
	assign avs_waitrequest = access & ~ack_q;
	wire take = access & ack_q;
	wire wr = take & avs_write;
	wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	// Address decode shared by the write strobes and the read mux
	wire sel_ctrl = (avs_address == `CMOU_OFS_CTRL);
	wire sel_count = (avs_address == `CMOU_OFS_COUNT);
	wire sel_cmp = (avs_address == `CMOU_OFS_CMP);
	wire sel_strobe = (avs_address == `CMOU_OFS_STROBE);
	wire sel_stat = (avs_address == `CMOU_OFS_STAT);
	wire sel_mask = (avs_address == `CMOU_OFS_MASK);
	wire sel_pin = (avs_address == `CMOU_OFS_PIN);
	wire wr_ctrl = wr & sel_ctrl;
	wire wr_count = wr & sel_count;
	wire wr_cmp = wr & sel_cmp;
	wire wr_strobe = wr & sel_strobe;
	wire wr_stat = wr & sel_stat;
	wire wr_mask = wr & sel_mask;
	// Lanes left out write zero rather than keep their old bits
	wire [31:0] wdata_m = avs_writedata & wmask;

	// A divider of zero gives a tick on every clock
	cmou_tick_div u_div (
		.clk(clk),
		.rst(rst),
		.run(ctrl_q.run),
		.divider(ctrl_q.divider),
		.tick(tick)
	);

	// Mode decode; counting uses only the mode field
	wire [3:0] wgm = ctrl_q.waveform_mode_select;
	wire mode_normal = (wgm == 4'h0);
	wire mode_ctc = (wgm == 4'h4) | (wgm == 4'hC);
	wire mode_fast = (wgm == 4'h5) | (wgm == 4'h6) | (wgm == 4'h7) |
		(wgm == 4'hE) | (wgm == 4'hF);
	wire mode_pwm = ~(mode_normal | mode_ctc | (wgm == 4'hD));
	wire mode_dual = mode_pwm & ~mode_fast;
	wire top_fix8 = (wgm == 4'h1) | (wgm == 4'h5);
	wire top_fix9 = (wgm == 4'h2) | (wgm == 4'h6);
	wire top_fix10 = (wgm == 4'h3) | (wgm == 4'h7);
	// Variable-top modes take top from the compare value of this channel
	wire [CW-1:0] top =
		top_fix8 ? CW'(`CMOU_TOP_8) :
		top_fix9 ? CW'(`CMOU_TOP_9) :
		top_fix10 ? CW'(`CMOU_TOP_10) :
		mode_normal ? CW'(`CMOU_COUNT_MAX) : cmp_q;
	wire at_top = (count_q == top);
	wire at_bottom = (count_q == CW'(`CMOU_COUNT_BOTTOM));
	wire at_max = (count_q == CW'(`CMOU_COUNT_MAX));

	// Comparator; a counter write masks matches for the next tick
	wire cmp_eq = (count_q == cmp_q);
	wire match = tick & cmp_eq & ~block_q;
	wire top_hit = tick & at_top & ~block_q;

	// Counting sequence; blocked top runs on to max and wraps
	always_comb
	begin
		count_d = count_q;
		down_d = down_q;
		// A write wins over a tick in the same cycle
		if (wr_count)
			count_d = wdata_m[CW-1:0];
		else if (tick)
		begin
			if (mode_dual)
			begin
				if (top_hit)
				begin
					down_d = 1'b1;
					count_d = count_q - CW'(1);
				end
				else if (down_q && at_bottom)
				begin
					down_d = 1'b0;
					count_d = count_q + CW'(1);
				end
				else if (down_q)
					count_d = count_q - CW'(1);
				else
					count_d = count_q + CW'(1);
			end
			else if ((mode_ctc || mode_fast) && top_hit)
				count_d = CW'(`CMOU_COUNT_BOTTOM);
			else if (at_max)
				count_d = CW'(`CMOU_COUNT_BOTTOM);
			else
				count_d = count_q + CW'(1);
		end
	end

	// Output state update; action field read live, never buffered
	wire [1:0] act = ctrl_q.output_action_select;
	// Strobe is a pulse only: nothing of it is kept for a later mode change
	wire force_one = wdata_m[0];
	wire force_hit = wr_strobe & force_one & ~mode_pwm;
	wire nonpwm_ev = match | force_hit;
	// Fast PWM: non-inverting sets at the match and clears at top
	wire fast_at_match = ~act[0];
	wire fast_at_top = act[0];
	always_comb
	begin
		oc_d = oc_q;
		if (act != CMOU_ACT_NONE)
		begin
			if (!mode_pwm && nonpwm_ev)
			begin
				case (act)
					CMOU_ACT_TOGGLE: oc_d = ~oc_q;
					CMOU_ACT_CLEAR: oc_d = 1'b0;
					CMOU_ACT_SET: oc_d = 1'b1;
					default: oc_d = oc_q;
				endcase
			end
			else if (mode_fast)
			begin
				// Inverting when the low action bit is set
				if (match)
					oc_d = fast_at_match;
				else if (top_hit)
					oc_d = fast_at_top;
			end
			else if (mode_dual && match)
				oc_d = act[0] ^ ~down_q;
		end
	end

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			count_q <= '0;
			down_q <= 1'b0;
			oc_q <= 1'b0;
			block_q <= 1'b0;
			match_pend_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			down_q <= down_d;
			oc_q <= oc_d;
			// Held across a stopped timer until the next tick consumes it
			block_q <= wr_count | (block_q & ~tick);
			match_pend_q <= match | (match_pend_q & ~tick);
		end

	// Flag sets on the tick after the match; set wins over clear
	wire set_match = match_pend_q & tick;
	wire ovf_dual = down_q & at_bottom;
	wire ovf_single = top_hit | at_max;
	wire set_ovf = tick & (mode_dual ? ovf_dual : ovf_single);
	wire [1:0] set_v = {set_ovf, set_match};
	// The interrupt acknowledge serves the match flag only; overflow needs a write
	wire [1:0] clr_sw = wr_stat ? wdata_m[1:0] : 2'b00;
	wire [1:0] clr_ack = {1'b0, irq_ack};
	wire [1:0] clr_v = clr_sw | clr_ack;
	wire [1:0] stat_d;
	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_stat
			assign stat_d[g] = set_v[g] | (stat_q[g] & ~clr_v[g]);
		end
	endgenerate

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			stat_q <= 2'b00;
			mask_q <= 2'b00;
			ctrl_q <= '0;
			cmp_q <= '0;
		end
		else
		begin
			stat_q <= stat_d;
			if (wr_mask)
				mask_q <= wdata_m[1:0];
			if (wr_ctrl)
			begin
				ctrl_q.waveform_mode_select <= wdata_m[`CMOU_CTRL_WGM_LSB+:4];
				ctrl_q.output_action_select <= wdata_m[`CMOU_CTRL_ACT_LSB+:2];
				ctrl_q.output_pin_direction_bit <= wdata_m[`CMOU_CTRL_DIR_BIT];
				ctrl_q.port_value <= wdata_m[`CMOU_CTRL_PORT_BIT];
				ctrl_q.run <= wdata_m[`CMOU_CTRL_RUN_BIT];
				ctrl_q.divider <= wdata_m[`CMOU_CTRL_DIV_LSB+:16];
			end
			if (wr_cmp)
				cmp_q <= wdata_m[CW-1:0];
		end

	assign irq = |(stat_q & mask_q);

	// Pin: override of port value, direction always from the direction bit
	// Registered pin: one cycle of delay buys a glitch-free pad
	wire pin_src = (|act) ? oc_q : ctrl_q.port_value;
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			pin.out <= 1'b0;
			pin.oe <= 1'b0;
		end
		else
		begin
			pin.out <= pin_src;
			pin.oe <= ctrl_q.output_pin_direction_bit;
		end

	// Read mux; strobe register reads zero
	wire [31:0] rd_ctrl = {ctrl_q.divider, 7'h00, ctrl_q.run, ctrl_q.port_value,
		ctrl_q.output_pin_direction_bit, ctrl_q.output_action_select,
		ctrl_q.waveform_mode_select};
	wire [31:0] rd_count = 32'(count_q);
	wire [31:0] rd_cmp = 32'(cmp_q);
	wire [31:0] rd_stat = {30'h0, stat_q};
	wire [31:0] rd_mask = {30'h0, mask_q};
	wire [31:0] rd_pin = {29'h0, down_q, oc_q, pin.out};
	// Strobe and unmapped words read zero, so nothing of the strobe shows
	wire [31:0] rd_mux =
		sel_ctrl ? rd_ctrl :
		sel_count ? rd_count :
		sel_cmp ? rd_cmp :
		sel_stat ? rd_stat :
		sel_mask ? rd_mask :
		sel_pin ? rd_pin :
		32'h00000000;

	// Read data are taken in the wait state, so every access costs two cycles
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= access & ~ack_q;
			if (avs_read & ~ack_q)
				rdata_q <= rd_mux;
		end
	assign avs_readdata = rdata_q;
endmodule : cmou_top

// *** verification/cmou_top_sva.sv ***
// Port assertions of the compare output unit
`timescale 1ns/100ps
`include "cmou_params.svh"
module cmou_top_sva
	import cmou_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Interrupt and pin
	input wire logic irq_ack,
	input wire logic irq,
	input wire cmou_pkg::cmou_pin_s pin
);
	logic [31:0] ctl_q;
	logic [1:0] msk_q;
	wire acc = avs_write && !avs_waitrequest;
	wire rdacc = avs_read && !avs_waitrequest;
	wire [31:0] wd = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	// Shadows let pin and interrupt be judged without seeing the bodies
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctl_q <= '0;
			msk_q <= '0;
		end
		else if (acc && avs_address == `CMOU_OFS_CTRL)
			ctl_q <= wd;
		else if (acc && avs_address == `CMOU_OFS_MASK)
			msk_q <= wd[1:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_wait; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("wait state not exactly one");
	property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("waitrequest without request");
	property p_rst; $fell(rst) |-> pin == '0; endproperty
	a_rst: assert property (p_rst) else $error("pin not cleared by reset");
	property p_oe; acc && avs_address == `CMOU_OFS_CTRL && avs_byteenable[0]
		|-> ##2 pin.oe == $past(avs_writedata[6], 2); endproperty
	a_oe: assert property (p_oe) else $error("pin enable differs from direction");
	property p_port; $past(ctl_q[5:4]) == 2'b00 && $stable(ctl_q) |-> pin.out == ctl_q[7];
	endproperty
	a_port: assert property (p_port) else $error("pin not port value");
	property p_stb; rdacc && (avs_address == `CMOU_OFS_STROBE || avs_address > `CMOU_OFS_PIN)
		|-> avs_readdata == '0; endproperty
	a_stb: assert property (p_stb) else $error("strobe or unmapped read not zero");
	property p_irq; msk_q == 2'b00 |-> !irq; endproperty
	a_irq: assert property (p_irq) else $error("interrupt while masked");
	property p_ctl; rdacc && avs_address == `CMOU_OFS_CTRL
		|-> (avs_readdata & 32'hFFFF01FF) == (ctl_q & 32'hFFFF01FF); endproperty
	a_ctl: assert property (p_ctl) else $error("control readback wrong");
	c_force: cover property (acc && avs_address == `CMOU_OFS_STROBE);
	c_irq: cover property ($rose(irq));
	c_oe: cover property ($rose(pin.oe));
endmodule : cmou_top_sva
bind cmou_top cmou_top_sva u_sva (.clk(clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq_ack(irq_ack), .irq(irq), .pin(pin));

// *** verification/compare_match_output_unit_tb.sv ***
// Self-checking bench of the compare output unit
`timescale 1ns/100ps
`include "cmou_params.svh"
`define chk(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module compare_match_output_unit_tb;
	import cmou_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic [3:0] avs_address = '0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq_ack = 0;
	logic irq;
	cmou_pin_s pin;
	logic [31:0] seed = 32'h8D1FAB15;
	logic [31:0] rdv, d, m;
	logic [3:0] be;
	logic [1:0] act;
	logic st;
	int mismatches = 0;
	int n_checks = 0;
	always #4 clk = ~clk;
	cmou_top dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_ack(irq_ack),
		.irq(irq), .pin(pin));
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function logic nxt(input logic [1:0] a, input logic s);
		return (a == 2'd1) ? ~s : (a == 2'd2) ? 1'b0 : (a == 2'd3) ? 1'b1 : s;
	endfunction : nxt
	// An idle edge after each access keeps two drives of a strobe apart
	task wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] b);
		avs_address <= a;
		avs_writedata <= v;
		avs_byteenable <= b;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : wr
	task rd(input logic [3:0] a);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest);
		rdv = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : rd
	task waitirq();
		for (int k = 0; k < 100 && irq !== 1'b1; k++) @(posedge clk);
	endtask : waitirq
	task conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`CMOU_OFS_PIN);
		`chk("state", 32'h0, rdv)
		for (int i = 0; i < 8; i++)
		begin
			d = xs();
			be = 4'(xs());
			m = d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
			wr(`CMOU_OFS_CMP, d, be);
			rd(`CMOU_OFS_CMP);
			`chk("cmp", m[15:0], rdv[15:0])
			rd(4'h8 + i[3:0]);
			`chk("unmapped", 32'h0, rdv)
		end
		st = 1'b0;
		for (int i = 0; i < 10; i++)
		begin
			// Direction stays input while the output state is preset
			act = (i < 4) ? i[1:0] : 2'(xs());
			d = (xs() & 32'h80) | {26'h0, act, 4'h0};
			wr(`CMOU_OFS_CTRL, d, 4'hF);
			wr(`CMOU_OFS_STROBE, 32'h1, 4'hF);
			st = nxt(act, st);
			rd(`CMOU_OFS_PIN);
			`chk("forced", st, rdv[1])
			`chk("pinout", (act != 2'd0) ? st : d[7], rdv[0])
		end
		rd(`CMOU_OFS_STAT);
		`chk("nofl", 1'b0, rdv[0])
		wr(`CMOU_OFS_CTRL, st ? 32'h65 : 32'h75, 4'hF);
		wr(`CMOU_OFS_STROBE, 32'h1, 4'hF);
		rd(`CMOU_OFS_PIN);
		`chk("pwmforce", st, rdv[1])
		wr(`CMOU_OFS_CTRL, 32'h0, 4'hF);
		wr(`CMOU_OFS_MASK, 32'h1, 4'hF);
		wr(`CMOU_OFS_CMP, 32'h40, 4'hF);
		wr(`CMOU_OFS_COUNT, 32'h40, 4'hF);
		wr(`CMOU_OFS_CTRL, 32'h100, 4'hF);
		repeat (30) @(posedge clk);
		rd(`CMOU_OFS_STAT);
		`chk("blocked", 1'b0, rdv[0])
		wr(`CMOU_OFS_COUNT, 32'h30, 4'hF);
		waitirq();
		`chk("irq", 1'b1, irq)
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		@(posedge clk);
		`chk("ack", 1'b0, irq)
		wr(`CMOU_OFS_COUNT, 32'h38, 4'hF);
		waitirq();
		`chk("irq2", 1'b1, irq)
		wr(`CMOU_OFS_STAT, 32'h1, 4'hF);
		`chk("w1c", 1'b0, irq)
		conclude();
	end
endmodule : compare_match_output_unit_tb
